// ===== lcdhp_top.sv
// lcd controller host port with apb registers and driver link
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module lcdhp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic register_select,
    input wire logic read_write_select,
    input wire logic bus_strobe,
    input wire logic [3:0] upper_data_lines_in,
    output logic [3:0] upper_data_lines_out,
    output logic upper_data_lines_oe,
    input wire logic [3:0] lower_data_lines_in,
    output logic [3:0] lower_data_lines_out,
    output logic lower_data_lines_oe,
    input wire logic oscillator_input,
    output logic shift_clock,
    output logic latch_pulse,
    output logic serial_pattern_out,
    output logic ac_phase_toggle,
    output logic [15:0] common_outputs,
    output logic irq
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic four_bit;
        logic ext_osc;
        logic scan_en;
        logic [1:0] duty;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] instr;
        logic [7:0] wdata;
        logic [6:0] addr_ptr;
        logic [7:0] rdata_host;
        logic [15:0] busy_len;
        logic [15:0] busy_cnt;
        logic [31:0] pattern;
        logic e_prev;
        logic osc_prev;
        logic [6:0] div_cnt;
        logic tick;
        logic nib_second;
        logic [3:0] nib_buf;
        logic [3:0] up_out;
        logic up_oe;
        logic [3:0] lo_out;
        logic lo_oe;
        logic irq;
    } lcdhp_top_st_t;
    lcdhp_top_st_t r_reg;
    lcdhp_top_st_t r_next;

    logic [11:0] sync_q;
    logic rs_s;
    logic rw_s;
    logic e_s;
    logic osc_s;
    logic [3:0] up_s;
    logic [3:0] lo_s;
    logic e_rise;
    logic e_fall;
    logic busy;
    logic complete;
    logic [2:0] ev;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;
    logic apb_wr;
    logic [31:0] rd_val;
    logic rd_err;

    lcdhp_sync #(.W(12)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({oscillator_input, bus_strobe, read_write_select,
            register_select, upper_data_lines_in, lower_data_lines_in}),
        .q(sync_q)
    );
    assign {osc_s, e_s, rw_s, rs_s, up_s, lo_s} = sync_q;

    assign e_rise = e_s && !r_reg.e_prev;
    assign e_fall = !e_s && r_reg.e_prev;
    assign busy = r_reg.busy_cnt != 16'h0000;
    assign complete = !r_reg.four_bit || r_reg.nib_second;
    // status byte: busy on the top line, pointer below
    assign rd_byte = rs_s ? r_reg.rdata_host : {busy, r_reg.addr_ptr};
    assign wr_byte = r_reg.four_bit ? {r_reg.nib_buf, up_s} : {up_s, lo_s};
    assign apb_wr = psel && penable && pwrite && r_reg.pready;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (paddr)
            lcdhp_pkg::OFS_CTRL: begin
                rd_val[lcdhp_pkg::CTRL_FOUR_BIT] = r_reg.four_bit;
                rd_val[lcdhp_pkg::CTRL_EXT_OSC] = r_reg.ext_osc;
                rd_val[lcdhp_pkg::CTRL_SCAN_EN] = r_reg.scan_en;
                rd_val[lcdhp_pkg::CTRL_DUTY_LO +: 2] = r_reg.duty;
            end
            lcdhp_pkg::OFS_STATUS: begin
                rd_val[2:0] = r_reg.status;
                rd_val[lcdhp_pkg::ST_BUSY] = busy;
            end
            lcdhp_pkg::OFS_MASK: rd_val[2:0] = r_reg.mask;
            lcdhp_pkg::OFS_HOSTWR: rd_val[15:0] = {r_reg.wdata, r_reg.instr};
            lcdhp_pkg::OFS_ADDRPTR:
                rd_val[15:0] = {r_reg.rdata_host, 1'b0, r_reg.addr_ptr};
            lcdhp_pkg::OFS_BUSYLEN: rd_val[15:0] = r_reg.busy_len;
            lcdhp_pkg::OFS_PATTERN: rd_val = r_reg.pattern;
            default: rd_err = 1'b1;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        ev = '0;
        // apb: one wait state, answer registered
        r_next.pready = psel && penable && !r_reg.pready;
        if (psel && penable && !r_reg.pready) begin
            r_next.prdata = pwrite ? 32'h0000_0000 : rd_val;
            r_next.pslverr = rd_err;
        end
        if (apb_wr && !rd_err) begin
            unique case (paddr)
                lcdhp_pkg::OFS_CTRL: begin
                    r_next.four_bit = pwdata[lcdhp_pkg::CTRL_FOUR_BIT];
                    r_next.ext_osc = pwdata[lcdhp_pkg::CTRL_EXT_OSC];
                    r_next.scan_en = pwdata[lcdhp_pkg::CTRL_SCAN_EN];
                    r_next.duty = pwdata[lcdhp_pkg::CTRL_DUTY_LO +: 2];
                    r_next.nib_second = 1'b0;
                end
                lcdhp_pkg::OFS_STATUS: r_next.status = r_reg.status & ~pwdata[2:0];
                lcdhp_pkg::OFS_MASK: r_next.mask = pwdata[2:0];
                lcdhp_pkg::OFS_ADDRPTR: begin
                    r_next.addr_ptr = pwdata[6:0];
                    r_next.rdata_host = pwdata[15:8];
                end
                lcdhp_pkg::OFS_BUSYLEN: r_next.busy_len = pwdata[15:0];
                lcdhp_pkg::OFS_PATTERN: r_next.pattern = pwdata;
                default: ;
            endcase
        end
        // host port
        r_next.e_prev = e_s;
        if (busy) begin
            r_next.busy_cnt = r_reg.busy_cnt - 16'h0001;
        end
        if (e_rise && rw_s) begin
            r_next.up_oe = 1'b1;
            if (r_reg.four_bit) begin
                r_next.up_out = r_reg.nib_second ? rd_byte[3:0] : rd_byte[7:4];
            end else begin
                r_next.up_out = rd_byte[7:4];
                r_next.lo_out = rd_byte[3:0];
                r_next.lo_oe = 1'b1;
            end
        end
        if (e_fall) begin
            r_next.up_oe = 1'b0;
            r_next.lo_oe = 1'b0;
            if (r_reg.four_bit) begin
                r_next.nib_second = !r_reg.nib_second;
                r_next.nib_buf = up_s;
            end
            if (complete && rw_s && rs_s) begin
                ev[lcdhp_pkg::EV_DATA_RD] = 1'b1;
            end
            if (complete && !rw_s && rs_s) begin
                r_next.wdata = wr_byte;
                r_next.busy_cnt = r_reg.busy_len;
                ev[lcdhp_pkg::EV_DATA_WR] = 1'b1;
            end
            if (complete && !rw_s && !rs_s && !busy) begin
                r_next.instr = wr_byte;
                r_next.busy_cnt = r_reg.busy_len;
                ev[lcdhp_pkg::EV_INSTR_WR] = 1'b1;
            end
        end
        // set wins over a same-cycle clear
        r_next.status = r_next.status | ev;
        r_next.irq = |(r_next.status & r_next.mask);
        // operating tick: divider or external oscillator edge
        r_next.osc_prev = osc_s;
        r_next.tick = 1'b0;
        if (r_reg.ext_osc) begin
            r_next.tick = osc_s && !r_reg.osc_prev;
            r_next.div_cnt = '0;
        end else if (r_reg.div_cnt == 7'(lcdhp_pkg::DIV_CYC - 1)) begin
            r_next.div_cnt = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.div_cnt = r_reg.div_cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{busy_len: lcdhp_pkg::BUSYLEN_RST,
                pattern: lcdhp_pkg::PATTERN_RST, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    lcdhp_scan_if u_if ();
    assign u_if.tick = r_reg.tick;
    assign u_if.enable = r_reg.scan_en;
    assign u_if.duty = r_reg.duty;
    assign u_if.pattern = r_reg.pattern;

    lcdhp_scan u_scan (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(u_if.scan),
        .shift_clock(shift_clock),
        .latch_pulse(latch_pulse),
        .serial_pattern_out(serial_pattern_out),
        .ac_phase_toggle(ac_phase_toggle),
        .common_outputs(common_outputs)
    );

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign upper_data_lines_out = r_reg.up_out;
    assign upper_data_lines_oe = r_reg.up_oe;
    assign lower_data_lines_out = r_reg.lo_out;
    assign lower_data_lines_oe = r_reg.lo_oe;
    assign irq = r_reg.irq;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_data_read;
        e_rise && rw_s && rs_s && !r_reg.four_bit |=>
            {upper_data_lines_out, lower_data_lines_out} ==
            $past(r_reg.rdata_host);
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("data read did not return data register");
    property p_write_no_drive;
        e_rise && !rw_s && !upper_data_lines_oe |=> !upper_data_lines_oe;
    endproperty
    a_write_no_drive: assert property (p_write_no_drive)
        else $error("bus driven during a write");
    property p_instr_on_strobe;
        $changed(r_reg.instr) |-> $past(e_fall) && $past(!rw_s);
    endproperty
    a_instr_on_strobe: assert property (p_instr_on_strobe)
        else $error("instruction taken without strobe fall");
    property p_drive_start;
        $rose(upper_data_lines_oe) |-> $past(e_rise && rw_s);
    endproperty
    a_drive_start: assert property (p_drive_start)
        else $error("bus drive began outside a read strobe");
    property p_lower_idle;
        r_reg.four_bit && $stable(r_reg.four_bit) |=> !lower_data_lines_oe;
    endproperty
    a_lower_idle: assert property (p_lower_idle)
        else $error("lower lines driven in four-bit mode");
    property p_ext_tick;
        $past(r_reg.ext_osc) && r_reg.tick |->
            $past(osc_s) && !$past(osc_s, 2);
    endproperty
    a_ext_tick: assert property (p_ext_tick)
        else $error("tick not from oscillator edge");
    property p_busy_refuse;
        busy |=> $stable(r_reg.instr);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("instruction accepted while busy");
    property p_status_read;
        e_rise && rw_s && !rs_s && !r_reg.four_bit |=>
            upper_data_lines_out[3] == $past(busy) &&
            {upper_data_lines_out[2:0], lower_data_lines_out} ==
            $past(r_reg.addr_ptr);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong busy or pointer");
    property p_nibble_pair;
        r_reg.four_bit && e_fall && !r_reg.nib_second |-> ev == 3'h0;
    endproperty
    a_nibble_pair: assert property (p_nibble_pair)
        else $error("transfer completed on the high nibble alone");
    c_nibble_write: cover property (r_reg.four_bit &&
        ev[lcdhp_pkg::EV_DATA_WR]);
    c_status_read: cover property (e_rise && rw_s && !rs_s);
    c_busy_refused: cover property (e_fall && !rw_s && !rs_s && busy &&
        complete);
endmodule // lcdhp_top

// ===== lcdhp_pkg.sv
// constants, register map and helpers for the lcd host port and driver link
// Function
// - select high reaches data, low instruction/status
// - read_write_select low writes, high reads
// - transfers happen only on bus strobe
// - upper lines driven only during reads
// - latch_pulse latches shifted pattern into driver
// - shift_clock advances pattern one position
// - ac_phase_toggle alternates liquid crystal drive
// - serial pattern bit one selects segment
// - unused commons carry non-selection waveform
// - external clock taken from oscillator_input
// - busy refuses new instruction writes
// - status read gives busy and pointer
package lcdhp_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_HOSTWR = 8'h0C;
    localparam logic [7:0] OFS_ADDRPTR = 8'h10;
    localparam logic [7:0] OFS_BUSYLEN = 8'h14;
    localparam logic [7:0] OFS_PATTERN = 8'h18;
    // control fields
    localparam int CTRL_FOUR_BIT = 0;
    localparam int CTRL_EXT_OSC = 1;
    localparam int CTRL_SCAN_EN = 2;
    localparam int CTRL_DUTY_LO = 4;
    // status / mask fields
    localparam int EV_INSTR_WR = 0;
    localparam int EV_DATA_WR = 1;
    localparam int EV_DATA_RD = 2;
    localparam int ST_BUSY = 8;
    localparam int NUM_EV = 3;
    // duty codes
    localparam logic [1:0] DUTY_8 = 2'h0;
    localparam logic [1:0] DUTY_11 = 2'h1;
    // reset values
    localparam logic [15:0] BUSYLEN_RST = 16'h0028;
    localparam logic [31:0] PATTERN_RST = 32'h0000_0000;
    // timing
    localparam int PERIOD_NS = 8;
    localparam int T_CLKW_NS = 800;
    localparam int DIV_CYC = (T_CLKW_NS + PERIOD_NS - 1) / PERIOD_NS;
    localparam int SEG_BITS = 32;
    localparam int NUM_COM = 16;

    function automatic logic [4:0] lcdhp_rows(input logic [1:0] duty);
        unique case (duty)
            DUTY_8: lcdhp_rows = 5'h08;
            DUTY_11: lcdhp_rows = 5'h0B;
            default: lcdhp_rows = 5'h10;
        endcase
    endfunction
endpackage

// ===== lcdhp_scan_if.sv
// control bundle between the host port core and the driver link scanner
`timescale 1ns/1ps
interface lcdhp_scan_if;
    logic tick;
    logic enable;
    logic [1:0] duty;
    logic [31:0] pattern;
    modport ctl (output tick, output enable, output duty, output pattern);
    modport scan (input tick, input enable, input duty, input pattern);
endinterface

// ===== lcdhp_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module lcdhp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lcdhp_sync_st_t;
    lcdhp_sync_st_t st_reg;
    lcdhp_sync_st_t st_next;

    always_comb begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule // lcdhp_sync

// ===== lcdhp_scan.sv
// serial pattern scanner toward the external column driver
`timescale 1ns/1ps
module lcdhp_scan (
    input wire logic pclk,
    input wire logic presetn,
    lcdhp_scan_if.scan ctl,
    output logic shift_clock,
    output logic latch_pulse,
    output logic serial_pattern_out,
    output logic ac_phase_toggle,
    output logic [15:0] common_outputs
);
    typedef enum logic [2:0] {S_IDLE, S_SET, S_HIGH, S_HOLD, S_LATCH}
        lcdhp_phase_t;
    typedef struct packed {
        lcdhp_phase_t ph;
        logic [4:0] bit_idx;
        logic [3:0] row;
        logic clk;
        logic latch;
        logic data;
        logic ac;
        logic [15:0] com;
    } lcdhp_scan_st_t;
    lcdhp_scan_st_t r_reg;
    lcdhp_scan_st_t r_next;
    logic [4:0] rows;
    logic [3:0] row_inc;

    assign rows = lcdhp_pkg::lcdhp_rows(ctl.duty);
    assign row_inc = r_reg.row + 4'h1;

    always_comb begin
        r_next = r_reg;
        if (!ctl.enable) begin
            r_next.ph = S_IDLE;
            r_next.clk = 1'b0;
            r_next.latch = 1'b0;
            r_next.data = 1'b0;
            r_next.com = '0;
        end else if (ctl.tick) begin
            unique case (r_reg.ph)
                S_IDLE: begin
                    r_next.ph = S_SET;
                    r_next.row = '0;
                    r_next.bit_idx = '0;
                    r_next.data = ctl.pattern[0];
                    r_next.com = 16'h0001;
                end
                S_SET: begin
                    r_next.clk = 1'b1;
                    r_next.ph = S_HIGH;
                end
                S_HIGH: begin
                    r_next.clk = 1'b0;
                    r_next.ph = S_HOLD;
                end
                S_HOLD: begin
                    if (r_reg.bit_idx == 5'(lcdhp_pkg::SEG_BITS - 1)) begin
                        r_next.latch = 1'b1;
                        r_next.ph = S_LATCH;
                    end else begin
                        r_next.bit_idx = r_reg.bit_idx + 5'h01;
                        r_next.data = ({1'b0, r_reg.row} < rows) &&
                            ctl.pattern[r_next.bit_idx];
                        r_next.ph = S_SET;
                    end
                end
                S_LATCH: begin
                    r_next.latch = 1'b0;
                    r_next.row = row_inc;
                    r_next.bit_idx = '0;
                    if (r_reg.row == 4'hF) begin
                        r_next.ac = !r_reg.ac;
                    end
                    // rows past the duty stay unselected
                    r_next.com = ({1'b0, row_inc} < rows) ?
                        16'(1) << row_inc : 16'h0000;
                    r_next.data = ({1'b0, row_inc} < rows) &&
                        ctl.pattern[0];
                    r_next.ph = S_SET;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{ph: S_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign shift_clock = r_reg.clk;
    assign latch_pulse = r_reg.latch;
    assign serial_pattern_out = r_reg.data;
    assign ac_phase_toggle = r_reg.ac;
    assign common_outputs = r_reg.com;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_latch_after_row;
        $rose(latch_pulse) |-> $past(r_reg.bit_idx) == 5'h1F && !shift_clock;
    endproperty
    a_latch_after_row: assert property (p_latch_after_row)
        else $error("latch pulse before full row shifted");
    property p_data_hold;
        $fell(shift_clock) |-> $stable(serial_pattern_out);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("pattern data changed at shift clock fall");
    property p_ac_frame;
        $changed(ac_phase_toggle) |-> $past(r_reg.row) == 4'hF &&
            $past(latch_pulse);
    endproperty
    a_ac_frame: assert property (p_ac_frame)
        else $error("ac phase toggled outside frame end");
    property p_unselected_rows;
        serial_pattern_out |-> {1'b0, r_reg.row} < rows;
    endproperty
    a_unselected_rows: assert property (p_unselected_rows)
        else $error("pattern bit driven on an unused row");
    property p_unused_commons;
        ctl.duty == lcdhp_pkg::DUTY_8 && $stable(ctl.duty) |=>
            common_outputs[15:8] == 8'h00;
    endproperty
    a_unused_commons: assert property (p_unused_commons)
        else $error("unused common selected at one-eighth duty");
    c_ac_toggle: cover property ($changed(ac_phase_toggle));
endmodule // lcdhp_scan

// ===== lcdhp_drv_model.sv
// column driver model: shifts the serial pattern and latches it
`timescale 1ns/1ps
module lcdhp_drv_model (
    input wire logic shift_clock,
    input wire logic latch_pulse,
    input wire logic serial_pattern_out,
    output logic [31:0] latched,
    output logic [15:0] latch_count
);
    logic [31:0] sr = 32'h0000_0000;
    logic [31:0] word = 32'h0000_0000;
    logic [15:0] cnt = 16'h0000;
    assign latched = word;
    assign latch_count = cnt;
    // first bit sent ends in bit 0 after a full row
    always @(negedge shift_clock) begin
        sr <= {serial_pattern_out, sr[31:1]};
    end
    // blank rows shift in zero and leave word alone, so it keeps the last lit row
    always @(posedge latch_pulse) begin
        cnt <= cnt + 16'h0001;
        if (sr != 32'h0000_0000) begin
            word <= sr;
        end
    end
endmodule // lcdhp_drv_model

// ===== testbench.sv
// self-checking bench for the lcd host port and driver link
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, word;
    logic rs, rw, strobe, osc, up_oe, lo_oe, sclk, latch, sdat, acp, irq;
    logic [3:0] up_in, lo_in, up_out, lo_out;
    logic [15:0] com, latches;
    int errors = 0;
    int comparisons = 0;

    lcdhp_top i_lcdhp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .register_select(rs), .read_write_select(rw),
        .bus_strobe(strobe), .upper_data_lines_in(up_in),
        .upper_data_lines_out(up_out), .upper_data_lines_oe(up_oe),
        .lower_data_lines_in(lo_in), .lower_data_lines_out(lo_out),
        .lower_data_lines_oe(lo_oe), .oscillator_input(osc),
        .shift_clock(sclk), .latch_pulse(latch),
        .serial_pattern_out(sdat), .ac_phase_toggle(acp),
        .common_outputs(com), .irq(irq));
    lcdhp_drv_model i_lcdhp_drv_model (.shift_clock(sclk),
        .latch_pulse(latch), .serial_pattern_out(sdat),
        .latched(word), .latch_count(latches));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        osc = 1'b0;
        #5;
        forever #32 osc = ~osc;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask

    // one strobed pin transfer; returns data and output enables
    task automatic pin(input logic r, input logic w, input logic [3:0] hi,
        input logic [3:0] lo, output logic [7:0] q, output logic [1:0] oe);
        @(posedge pclk);
        rs <= r;
        rw <= w;
        up_in <= hi;
        lo_in <= lo;
        repeat (4) @(posedge pclk);
        strobe <= 1'b1;
        repeat (8) @(posedge pclk);
        q = {up_out, lo_out};
        oe = {up_oe, lo_oe};
        strobe <= 1'b0;
        repeat (6) @(posedge pclk);
        up_in <= ~hi;
        lo_in <= ~lo;
        chk({30'h0, up_oe, lo_oe}, 32'h0000_0000);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rdchk(lcdhp_pkg::OFS_BUSYLEN, 32'h0000_0028);
        rdchk(lcdhp_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000, q, e);
        chk({31'h0, e}, 32'h0000_0001);
    endtask

    task automatic t_status();
        logic [7:0] q;
        logic [1:0] oe;
        wr(lcdhp_pkg::OFS_ADDRPTR, 32'h0000_5A35);
        pin(1'b0, 1'b1, 4'h0, 4'h0, q, oe);
        chk({24'h0, q}, 32'h0000_0035);
        chk({30'h0, oe}, 32'h0000_0003);
        pin(1'b1, 1'b1, 4'h0, 4'h0, q, oe);
        chk({24'h0, q}, 32'h0000_005A);
    endtask

    task automatic t_instr();
        logic [7:0] q;
        logic [1:0] oe;
        logic [31:0] s;
        logic e;
        int n;
        wr(lcdhp_pkg::OFS_BUSYLEN, 32'h0000_0100);
        wr(lcdhp_pkg::OFS_MASK, 32'h0000_0001);
        pin(1'b0, 1'b0, 4'hA, 4'h5, q, oe);
        rdchk(lcdhp_pkg::OFS_HOSTWR, 32'h0000_00A5);
        chk({31'h0, irq}, 32'h0000_0001);
        pin(1'b0, 1'b1, 4'h0, 4'h0, q, oe);
        chk({24'h0, q}, 32'h0000_00B5);
        pin(1'b0, 1'b0, 4'h3, 4'hC, q, oe);
        rdchk(lcdhp_pkg::OFS_HOSTWR, 32'h0000_00A5);
        n = 0;
        do begin
            apb(1'b0, lcdhp_pkg::OFS_STATUS, 32'h0000_0000, s, e);
            n++;
        end while (s[lcdhp_pkg::ST_BUSY] !== 1'b0 && n < 200);
        chk({31'h0, s[lcdhp_pkg::ST_BUSY]}, 32'h0000_0000);
        wr(lcdhp_pkg::OFS_STATUS, 32'h0000_0007);
        rdchk(lcdhp_pkg::OFS_STATUS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic t_four();
        logic [7:0] q;
        logic [7:0] q2;
        logic [1:0] oe;
        wr(lcdhp_pkg::OFS_CTRL, 32'h0000_0001);
        pin(1'b1, 1'b0, 4'h9, 4'hF, q, oe);
        pin(1'b1, 1'b0, 4'h6, 4'h0, q, oe);
        rdchk(lcdhp_pkg::OFS_HOSTWR, 32'h0000_96A5);
        rdchk(lcdhp_pkg::OFS_STATUS, 32'h0000_0102);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(lcdhp_pkg::OFS_ADDRPTR, 32'h0000_C335);
        pin(1'b1, 1'b1, 4'h0, 4'h0, q, oe);
        chk({30'h0, oe}, 32'h0000_0002);
        pin(1'b1, 1'b1, 4'h0, 4'h0, q2, oe);
        chk({24'h0, q[7:4], q2[7:4]}, 32'h0000_00C3);
        wr(lcdhp_pkg::OFS_STATUS, 32'h0000_0007);
    endtask

    // waits for a frame start, then gathers commons over one whole frame
    task automatic frame(input logic [31:0] ctrl, input logic [15:0] exp);
        logic a0;
        logic [15:0] seen;
        int n;
        seen = 16'h0000;
        wr(lcdhp_pkg::OFS_CTRL, ctrl);
        for (int k = 0; k < 2; k++) begin
            a0 = acp;
            n = 0;
            while (acp === a0 && n < 30000) begin
                if (k == 1) begin
                    seen = seen | com;
                end
                @(posedge pclk);
                n++;
            end
            chk({31'h0, acp}, {31'h0, ~a0});
        end
        chk({16'h0, seen}, {16'h0, exp});
    endtask

    task automatic t_link();
        int n;
        wr(lcdhp_pkg::OFS_PATTERN, 32'h8421_0013);
        wr(lcdhp_pkg::OFS_CTRL, 32'h0000_0006);
        n = 0;
        while (latches < 16'h0003 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, latches >= 16'h0003}, 32'h0000_0001);
        chk(word, 32'h8421_0013);
        frame(32'h0000_0006, 16'h00FF);
        frame(32'h0000_0016, 16'h07FF);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rs = 1'b0;
        rw = 1'b1;
        strobe = 1'b0;
        up_in = 4'h0;
        lo_in = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_status();
        t_instr();
        t_four();
        t_link();
        print_verdict();
    end
endmodule // testbench
